// File: src/hcp_pkg.sv
// shared constants and bundles of the host cpu bus port
package hcp_pkg;

	// ******************************
	// widths
	// ******************************
	localparam int HCP_ADDR_W = 15;
	localparam int HCP_DATA_W = 16;

	// ******************************
	// timing
	// ******************************
	localparam int HCP_CLK_PERIOD_PS = 5000;
	localparam int HCP_SYNC_STAGES = 3;
	localparam int HCP_ACK_MIN_NS = 100;
	localparam int HCP_ACK_MAX_NS = 1000;
	localparam int HCP_DATA_SETUP_NS = 15;
	localparam int HCP_ACK_MIN_CYC = (HCP_ACK_MIN_NS * 1000 + HCP_CLK_PERIOD_PS - 1) / HCP_CLK_PERIOD_PS;
	localparam int HCP_ACK_MAX_CYC = (HCP_ACK_MAX_NS * 1000) / HCP_CLK_PERIOD_PS;
	localparam int HCP_DATA_SETUP_CYC = (HCP_DATA_SETUP_NS * 1000 + HCP_CLK_PERIOD_PS - 1) / HCP_CLK_PERIOD_PS;
	localparam int HCP_ACK_LIMIT_CYC = HCP_ACK_MAX_CYC - HCP_SYNC_STAGES - 2;
	localparam int HCP_TIMEOUT_CYC = HCP_ACK_LIMIT_CYC - HCP_DATA_SETUP_CYC;
	localparam int HCP_CNT_W = $clog2(HCP_ACK_MAX_CYC + 1);

	// ******************************
	// reset values
	// ******************************
	localparam logic [HCP_DATA_W-1:0] HCP_RDATA_RST = 16'h0000;

	// ******************************
	// bundles
	// ******************************
	typedef struct packed {
		logic dataStrobeMode;
		logic csN;
		logic rdN;
		logic wrN;
		logic data_strobe_n;
		logic readNotWrite;
		logic memory_space_select;
		logic [HCP_ADDR_W-1:0] wordAddr;
		logic [HCP_DATA_W-1:0] wdata;
	} hcp_pins_s;

	localparam int HCP_PINS_W = $bits(hcp_pins_s);

	typedef struct packed {
		logic write;
		logic memory_space_select;
		logic [HCP_ADDR_W-1:0] wordAddr;
		logic [HCP_DATA_W-1:0] wdata;
	} hcp_req_s;

	typedef struct packed {
		logic valid;
		logic [HCP_DATA_W-1:0] rdata;
	} hcp_rsp_s;

	typedef enum logic [2:0] {
		HCP_IDLE,
		HCP_WAIT,
		HCP_SETUP,
		HCP_ACK,
		HCP_END
	} hcp_state_e;

endpackage : hcp_pkg

// File: src/hcp_sync.sv
// three stage input synchroniser with agreement filter
`timescale 1ns/1ps
module hcp_sync
	import hcp_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	// ******************************
	// elaboration check
	// ******************************
	if (WIDTH < 1) begin : g_badWidth
		$error("hcp_sync: WIDTH must be at least one");
	end

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage3_q;
	logic [WIDTH-1:0] held_q;
	logic [WIDTH-1:0] agree;

	// ******************************
	// stages
	// ******************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			stage2_q <= RST_VAL;
			stage3_q <= RST_VAL;
			held_q <= RST_VAL;
		end else begin
			meta_q <= asyncIn;
			stage2_q <= meta_q;
			stage3_q <= stage2_q;
			held_q <= syncOut;
		end
	end

	// a bit changes only once stages two and three agree
	assign agree = ~(stage2_q ^ stage3_q);
	assign syncOut = (agree & stage3_q) | (~agree & held_q);

endmodule : hcp_sync

// File: src/hcp_host_port.sv
// host cpu bus port: strobe-pair and data-strobe styles
`timescale 1ns/1ps

module hcp_host_port
	import hcp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic dataStrobeMode,
	input wire logic csN,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic data_strobe_n,
	input wire logic readNotWrite,
	input wire logic memory_space_select,
	input wire logic [hcp_pkg::HCP_ADDR_W-1:0] wordAddr,
	input wire logic [hcp_pkg::HCP_DATA_W-1:0] dataIn,
	output logic [hcp_pkg::HCP_DATA_W-1:0] dataOut,
	output logic dataOeN,
	output logic ready,
	output logic transfer_acknowledge_n,
	output logic transferAckOeN,
	output logic regReqValid,
	output logic memReqValid,
	output hcp_pkg::hcp_req_s req,
	input wire hcp_pkg::hcp_rsp_s regRsp,
	input wire hcp_pkg::hcp_rsp_s memRsp,
	output logic accessTimeout
);

	// ******************************
	// elaboration check
	// ******************************
	if (HCP_SYNC_STAGES != 3) begin : g_badSync
		$error("hcp_host_port: pin path needs three stages");
	end

	if (HCP_DATA_SETUP_CYC < 1) begin : g_badSetup
		$error("hcp_host_port: read data setup must be at least one cycle");
	end

	if (HCP_ACK_MIN_CYC < 1 || HCP_TIMEOUT_CYC <= HCP_ACK_MIN_CYC) begin : g_badTiming
		$error("hcp_host_port: acknowledge window cannot be met at this clock");
	end

	localparam logic [HCP_CNT_W-1:0] ACK_MIN = HCP_CNT_W'(HCP_ACK_MIN_CYC);
	localparam logic [HCP_CNT_W-1:0] TIMEOUT = HCP_CNT_W'(HCP_TIMEOUT_CYC);
	localparam logic [HCP_CNT_W-1:0] SETUP_LAST = HCP_CNT_W'(HCP_DATA_SETUP_CYC - 1);
	localparam hcp_pins_s PINS_RST = '{
		dataStrobeMode: 1'b0,
		csN: 1'b1,
		rdN: 1'b1,
		wrN: 1'b1,
		data_strobe_n: 1'b1,
		readNotWrite: 1'b1,
		memory_space_select: 1'b0,
		wordAddr: '0,
		wdata: '0
	};

	// ******************************
	// declarations
	// ******************************
	hcp_pins_s pinsRaw;
	hcp_pins_s pins;
	hcp_state_e state_q;
	hcp_state_e state_d;
	logic [HCP_CNT_W-1:0] cnt_q;
	logic [HCP_CNT_W-1:0] cnt_d;
	logic [HCP_CNT_W-1:0] setupCnt_q;
	logic [HCP_CNT_W-1:0] setupCnt_d;
	logic pending_q;
	logic driveData_q;
	logic [HCP_DATA_W-1:0] rdata_q;
	hcp_req_s req_q;
	logic regReqValid_q;
	logic memReqValid_q;
	logic timeout_q;
	logic dsMode;
	logic active;
	logic isWrite;
	logic start;
	logic rspValid;
	logic [HCP_DATA_W-1:0] rspData;
	logic waitDone;
	logic waitTimeout;
	logic setupDone;
	logic ackPhase;
	hcp_rsp_s rspSel;
	logic inWait;
	logic inAck;
	logic ackDrive;

	// ******************************
	// answer selection
	// ******************************
	function automatic hcp_rsp_s pickRsp(input logic toMem, input hcp_rsp_s fromReg, input hcp_rsp_s fromMem);
		return toMem ? fromMem : fromReg;
	endfunction : pickRsp

	// ******************************
	// pin synchronisation
	// ******************************
	assign pinsRaw = '{
		dataStrobeMode: dataStrobeMode,
		csN: csN,
		rdN: rdN,
		wrN: wrN,
		data_strobe_n: data_strobe_n,
		readNotWrite: readNotWrite,
		memory_space_select: memory_space_select,
		wordAddr: wordAddr,
		wdata: dataIn
	};

	hcp_sync #(
		.WIDTH(HCP_PINS_W),
		.RST_VAL(PINS_RST)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.asyncIn(pinsRaw),
		.syncOut(pins)
	);

	// ******************************
	// cycle decode
	// ******************************
	assign dsMode = pins.dataStrobeMode;
	assign active = !pins.csN && (dsMode ? !pins.data_strobe_n : (!pins.rdN || !pins.wrN));
	assign isWrite = dsMode ? !pins.readNotWrite : !pins.wrN;
	assign start = (state_q == HCP_IDLE) && active && !pending_q;
	assign rspSel = pickRsp(req_q.memory_space_select, regRsp, memRsp);
	assign rspValid = pending_q && rspSel.valid;
	assign rspData = rspSel.rdata;
	assign inWait = (state_q == HCP_WAIT);
	assign inAck = (state_q == HCP_ACK);
	assign waitDone = inWait && rspValid;
	assign waitTimeout = inWait && !rspValid && (cnt_q >= TIMEOUT);
	assign setupDone = (cnt_q >= ACK_MIN) && (setupCnt_q >= SETUP_LAST);
	assign ackPhase = inAck && active;

	// ******************************
	// state machine
	// ******************************
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		setupCnt_d = setupCnt_q;
		unique case (state_q)
			HCP_IDLE: begin
				cnt_d = '0;
				setupCnt_d = '0;
				if (start) begin
					state_d = HCP_WAIT;
				end
			end
			HCP_WAIT: begin
				cnt_d = cnt_q + 1'b1;
				if (!active) begin
					state_d = HCP_END;
				end else if (waitDone || waitTimeout) begin
					state_d = HCP_SETUP;
				end
			end
			HCP_SETUP: begin
				cnt_d = cnt_q + 1'b1;
				setupCnt_d = setupCnt_q + 1'b1;
				if (!active) begin
					state_d = HCP_END;
				end else if (setupDone) begin
					state_d = HCP_ACK;
				end
			end
			HCP_ACK: begin
				if (!active) begin
					state_d = HCP_END;
				end
			end
			HCP_END: begin
				state_d = HCP_IDLE;
			end
			default: begin
				state_d = HCP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= HCP_IDLE;
			cnt_q <= '0;
			setupCnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			setupCnt_q <= setupCnt_d;
		end
	end

	// ******************************
	// request to back end
	// ******************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_q <= '0;
		end else if (start) begin
			req_q <= '{
				write: isWrite,
				memory_space_select: pins.memory_space_select,
				wordAddr: pins.wordAddr,
				wdata: pins.wdata
			};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regReqValid_q <= 1'b0;
			memReqValid_q <= 1'b0;
		end else begin
			regReqValid_q <= start && !pins.memory_space_select;
			memReqValid_q <= start && pins.memory_space_select;
		end
	end

	// a timeout closes the request too, but a cycle the host ends before the timeout leaves pending_q set and blocks start until the back end answers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pending_q <= 1'b0;
		end else if (start) begin
			pending_q <= 1'b1;
		end else if (rspValid || waitTimeout) begin
			pending_q <= 1'b0;
		end
	end

	// ******************************
	// read data and timeout
	// ******************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= HCP_RDATA_RST;
		end else if (waitDone) begin
			rdata_q <= rspData;
		end else if (waitTimeout) begin
			rdata_q <= HCP_RDATA_RST;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timeout_q <= 1'b0;
		end else begin
			timeout_q <= waitTimeout;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			driveData_q <= 1'b0;
		end else if ((waitDone || waitTimeout) && active && !req_q.write) begin
			driveData_q <= 1'b1;
		end else if (state_q == HCP_END || state_q == HCP_IDLE) begin
			driveData_q <= 1'b0;
		end
	end

	// ******************************
	// pin outputs
	// ******************************
	assign dataOut = rdata_q;
	assign dataOeN = !(driveData_q && active);
	assign ready = !(!dsMode && active && !inAck);
	assign transfer_acknowledge_n = !ackPhase;
	assign ackDrive = dsMode && (active || state_q != HCP_IDLE);
	assign transferAckOeN = !ackDrive;
	assign regReqValid = regReqValid_q;
	assign memReqValid = memReqValid_q;
	assign req = req_q;
	assign accessTimeout = timeout_q;

endmodule : hcp_host_port

// File: verification/hcp_host_model.sv
// host processor model driving the port pins
`timescale 1ns/1ps
module hcp_host_model (
	input logic clk,
	input logic ready,
	input logic transfer_acknowledge_n,
	input logic transferAckOeN,
	input logic [15:0] dataOut,
	input logic dataOeN,
	output logic csN,
	output logic rdN,
	output logic wrN,
	output logic data_strobe_n,
	output logic readNotWrite,
	output logic memory_space_select,
	output logic [14:0] wordAddr,
	output logic [15:0] dataIn
);
	initial {csN, rdN, wrN, data_strobe_n, readNotWrite, memory_space_select, wordAddr, dataIn} = '1;
	task automatic access(input logic ds, wr, mem, input logic [14:0] a, input logic [15:0] d, input int ab,
		output logic [15:0] rd, output logic ok);
		int n;
		n = 0;
		ok = 0;
		@(posedge clk);
		#1 {readNotWrite, memory_space_select, wordAddr, dataIn} = {!wr, mem, a, d};
		{csN, data_strobe_n, wrN, rdN} = {1'b0, !ds, ds | !wr, ds | wr};
		repeat (5) @(posedge clk);
		#1;
		while (!ok && n < 250 && (ab == 0 || n < ab)) begin
			ok = ds ? !(transferAckOeN | transfer_acknowledge_n) : ready;
			rd = dataOeN ? 'x : dataOut;
			@(posedge clk);
			#1 n++;
		end
		{csN, rdN, wrN, data_strobe_n} = '1;
		dataIn = ~dataIn;
		repeat (6) @(posedge clk);
	endtask : access
endmodule : hcp_host_model

// File: verification/hcp_host_port_asserts.sv
// assertions on the host cpu bus port pins
`timescale 1ns/1ps
module hcp_host_port_asserts
	import hcp_pkg::*;
(
	input logic clk,
	input logic rst_n,
	input logic dataStrobeMode,
	input logic csN,
	input logic rdN,
	input logic wrN,
	input logic data_strobe_n,
	input logic memory_space_select,
	input logic [HCP_ADDR_W-1:0] wordAddr,
	input logic dataOeN,
	input logic ready,
	input logic transfer_acknowledge_n,
	input logic transferAckOeN,
	input logic regReqValid,
	input logic memReqValid,
	input hcp_req_s req
);
	logic act;
	logic [7:0] cnt_q;
	assign act = !csN && (dataStrobeMode ? !data_strobe_n : !(rdN && wrN));
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) cnt_q <= 8'h00;
		else cnt_q <= act ? cnt_q + 8'h01 : 8'h00;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	chk_ready_drop: assert property (!dataStrobeMode && $rose(act) |-> ##[1:4] !ready)
		else $error("ready kept");
	chk_ack_window: assert property ($rose(ready) && act || $fell(transfer_acknowledge_n)
		|-> cnt_q inside {[8'h14:8'hC8]}) else $error("ack timing");
	chk_ack_driven: assert property (dataStrobeMode && $rose(act)
		|-> ##[1:7] !transferAckOeN && transfer_acknowledge_n) else $error("ack undriven");
	chk_rdata_setup: assert property ($rose(ready) && act && !rdN |-> $past(dataOeN, 2) == 1'b0)
		else $error("data late");
	chk_data_float: assert property ($fell(act) |-> ##[1:4] dataOeN)
		else $error("data kept");
	chk_ack_release: assert property (dataStrobeMode && $fell(act)
		|-> ##[1:4] transfer_acknowledge_n ##[1:2] transferAckOeN) else $error("ack release");
	chk_route_target: assert property (regReqValid || memReqValid
		|-> memReqValid == memory_space_select && regReqValid != memReqValid && req.wordAddr == wordAddr)
		else $error("bad route");
	chk_one_op: assert property ($rose(act) |-> ##[2:8] $rose(regReqValid || memReqValid)
		##1 !(regReqValid || memReqValid) [*8]) else $error("op count");
	cover property (!dataStrobeMode && $rose(ready) && act);
	cover property ($fell(transfer_acknowledge_n));
	cover property (memReqValid);
endmodule : hcp_host_port_asserts
bind hcp_host_port hcp_host_port_asserts hcp_host_port_asserts_inst (.*);

// File: verification/hcp_host_port_tb.sv
// self-checking bench of the host cpu bus port
`timescale 1ns/1ps
module hcp_host_port_tb;
	import hcp_pkg::*;
	logic clk, rst_n, dataStrobeMode, csN, rdN, wrN, data_strobe_n, readNotWrite, memory_space_select, ok, isMem;
	logic dataOeN, ready, transfer_acknowledge_n, transferAckOeN, regReqValid, memReqValid, accessTimeout;
	logic [14:0] wordAddr;
	logic [15:0] dataIn, dataOut, rd;
	hcp_req_s req, got;
	hcp_rsp_s regRsp, memRsp;
	int fails, comparisons, cyc, dly, left, ops, tmo;
	hcp_host_port hcp_host_port_inst (.*);
	hcp_host_model hcp_host_model_inst (.*);
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		regRsp.valid <= 1'b0;
		memRsp.valid <= 1'b0;
		if (left == 1 && isMem) memRsp <= {1'b1, got.memory_space_select, got.wordAddr};
		if (left == 1 && !isMem) regRsp <= {1'b1, got.memory_space_select, got.wordAddr};
		if (left > 0) left--;
		if (regReqValid || memReqValid) begin
			isMem = memReqValid;
			got = req;
			left = dly;
			ops++;
		end
		if (accessTimeout) tmo++;
		if (++cyc == 4000) begin
			fails++;
			print_verdict();
		end
	end
	task automatic chk(input string n, input logic [15:0] e, s);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic print_verdict();
		if (fails == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict
	task automatic xfer(input logic ds, wr, mem, input logic [14:0] a, input int ab);
		int o;
		o = ops;
		#1 dataStrobeMode = ds;
		repeat (4) @(posedge clk);
		hcp_host_model_inst.access(ds, wr, mem, a, ~{a, mem}, ab, rd, ok);
		chk("ack", 16'(ab == 0), 16'(ok));
		chk("ops", 16'(o + 1), 16'(ops));
		chk("req", {mem, a}, {got.memory_space_select, got.wordAddr});
		chk("dir", 16'(wr), 16'(got.write));
		if (wr) chk("wdata", ~{a, mem}, got.wdata);
	endtask : xfer
	task automatic pair_style();
		dly = 1;
		xfer(0, 0, 0, 15'h7FFF, 0);
		chk("rdata", 16'h7FFF, rd);
		dly = 90;
		xfer(0, 0, 1, 15'h0000, 0);
		chk("rdata", 16'h8000, rd);
		xfer(0, 1, 1, 15'h1234, 0);
	endtask : pair_style
	task automatic ds_style();
		dly = 5;
		for (int i = 0; i < 4; i++) begin
			xfer(1, i[1], i[0], 15'h2AAA, 0);
			if (!i[1]) chk("rdata", {i[0], 15'h2AAA}, rd);
		end
	endtask : ds_style
	task automatic timeout_read();
		dly = 0;
		xfer(0, 0, 0, 15'h0100, 0);
		chk("rdata", 16'h0000, rd);
		chk("timeouts", 16'h0001, 16'(tmo));
	endtask : timeout_read
	task automatic abort_read();
		dly = 2;
		xfer(1, 0, 0, 15'h0042, 10);
		xfer(1, 0, 1, 15'h0043, 0);
		chk("rdata", 16'h8043, rd);
	endtask : abort_read
	initial begin
		rst_n = 0;
		dataStrobeMode = 0;
		regRsp = '0;
		memRsp = '0;
		repeat (5) @(posedge clk);
		#1 rst_n = 1;
		pair_style();
		ds_style();
		timeout_read();
		abort_read();
		print_verdict();
	end
endmodule : hcp_host_port_tb
